// >>> rtl/mlc_top.sv
// Notes on behaviour
// RL1: Ten-bit lost-frame tally in bits 6 to 15.
// RL2: Lost tally 1FFh to 200h raises enabled interrupt.
// RL3: Lost tally wraps after 3FFh; host reads early.
// RL4: Reading lost counter returns tally, then clears.
// RL5: Lost counter low six bits read 010000.
// RL6: Collision during transmit adds one to tally.
// RL7: Collision tally 1FFh to 200h raises interrupt.
// RL8: Collision tally wraps after 3FFh; host reads early.
// RL9: Reading collision counter returns tally, then clears.
// RL10: Collision counter low six bits read 010010.
// RL11: Line configuration low six bits read 010011.
// RL12: Backoff clear uses standard truncated exponential backoff.
// RL13: Modified backoff lengthens first three collision delays.
// RL14: Polarity fix corrects reversed pair unless disabled.
// RL15: Two-part deferral unless its disable bit set.
// RL16: Port select decodes AUI, twisted pair, automatic.
// RL17: Serial enables gate frames at frame boundaries.
`include "mlc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module mlc_top (
  // Clock and reset.
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // Host register port.
  input  wire mlc_pkg::mlc_word_t i_reg_addr,
  input  wire logic               i_reg_rd,
  input  wire logic               i_reg_wr,
  input  wire mlc_pkg::mlc_word_t i_reg_wdata,
  output logic [15:0]             o_reg_rdata,
  // Interrupt enables held in the buffer configuration register.
  input  wire logic               i_lost_tally_half_irq_enable,
  input  wire logic               i_collision_tally_half_irq_enable,
  output logic                    o_lost_half_irq,
  output logic                    o_col_half_irq,
  // Receive side.
  input  wire logic               i_rx_frame_lost,
  input  wire logic               i_rx_busy,
  input  wire logic               i_rx_data,
  input  wire logic               i_rx_pol_reversed,
  output logic                    o_rx_data_fixed,
  output logic                    o_rx_gate,
  // Transmit side.
  input  wire logic               i_tx_busy,
  input  wire logic               i_col_sense,
  input  wire logic               i_link_ok,
  input  wire logic               i_backoff_req,
  input  wire mlc_pkg::mlc_attempt_t i_attempt,
  output logic                    o_tx_gate,
  output logic                    o_two_part_defer,
  output logic                    o_use_aui,
  output logic                    o_use_tp,
  output logic [9:0]              o_backoff_slots,
  output logic                    o_backoff_valid
);
  import mlc_pkg::*;

  // One clock domain: every assertion below uses this clock and reset.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // ****************************************************************
  // Register access decode.
  // ****************************************************************
  logic       rd_lost;
  logic       rd_col;
  logic       wr_line;
  logic       col_d_r;
  logic       lost_inc;
  logic       col_inc;
  mlc_word_t  line_r;
  mlc_tally_t lost_r;
  mlc_tally_t col_r;
  mlc_port_t  port_r;
  logic [9:0] lfsr_r;
  logic [3:0] boff_exp;
  logic [9:0] boff_mask;

  assign rd_lost  = i_reg_rd && (i_reg_addr == `MLC_OFS_LOST_CNT);
  assign rd_col   = i_reg_rd && (i_reg_addr == `MLC_OFS_COL_CNT);
  assign wr_line  = i_reg_wr && (i_reg_addr == `MLC_OFS_LINE_CFG);
  assign lost_inc = i_rx_frame_lost;
  // Only the rising edge counts, so one long collision is one count.
  assign col_inc  = i_col_sense && !col_d_r && i_tx_busy; // RL6

  // ****************************************************************
  // Line configuration register.
  // ****************************************************************
  // Identifier bits are constants; only the mask bits are stored.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      line_r <= `MLC_LINE_RST;
    else if (wr_line)
      line_r <= (i_reg_wdata & `MLC_LINE_WMASK)
                | 16'(`MLC_ID_LINE); // RL11
  end

  // ****************************************************************
  // Tallies.
  // ****************************************************************
  // A count arriving with the read is kept: the read clears, the event
  // then leaves one count behind. Wrap past 3FFh is natural rollover.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lost_r <= 10'h000;
    else if (rd_lost)
      lost_r <= lost_inc ? 10'h001 : 10'h000; // RL4
    else if (lost_inc)
      lost_r <= lost_r + 10'h001; // RL1 RL3
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      col_r <= 10'h000;
    else if (rd_col)
      col_r <= col_inc ? 10'h001 : 10'h000; // RL9
    else if (col_inc)
      col_r <= col_r + 10'h001; // RL6 RL8
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      col_d_r <= 1'b0;
    else
      col_d_r <= i_col_sense;
  end

  // Half-range warnings fire on the step from 1FFh to 200h.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_lost_half_irq <= 1'b0;
      o_col_half_irq  <= 1'b0;
    end
    else
    begin
      o_lost_half_irq <= i_lost_tally_half_irq_enable && lost_inc
                         && !rd_lost && lost_r == `MLC_TALLY_HALF_M1; // RL2
      o_col_half_irq  <= i_collision_tally_half_irq_enable && col_inc
                         && !rd_col && col_r == `MLC_TALLY_HALF_M1; // RL7
    end
  end

  // ****************************************************************
  // Read data, one cycle after the read strobe.
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= 16'h0000;
    else if (rd_lost)
      o_reg_rdata <= {lost_r, `MLC_ID_LOST}; // RL4 RL5
    else if (rd_col)
      o_reg_rdata <= {col_r, `MLC_ID_COL}; // RL9 RL10
    else if (i_reg_rd && i_reg_addr == `MLC_OFS_LINE_CFG)
      o_reg_rdata <= line_r; // RL11
    else if (i_reg_rd)
      o_reg_rdata <= 16'h0000;
  end

  // ****************************************************************
  // Serial gating, polarity and deferral.
  // ****************************************************************
  // Gates change only between frames so a frame in flight completes.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rx_gate <= 1'b0;
      o_tx_gate <= 1'b0;
    end
    else
    begin
      if (!i_rx_busy)
        o_rx_gate <= line_r[`MLC_BIT_RX_EN]; // RL17
      if (!i_tx_busy)
        o_tx_gate <= line_r[`MLC_BIT_TX_EN]; // RL17
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rx_data_fixed  <= 1'b0;
      o_two_part_defer <= 1'b1;
    end
    else
    begin
      o_rx_data_fixed  <= i_rx_data ^ (i_rx_pol_reversed
                          && !line_r[`MLC_BIT_POL_DIS]); // RL14
      o_two_part_defer <= !line_r[`MLC_BIT_DEF_DIS]; // RL15
    end
  end

  // ****************************************************************
  // Port selection.
  // ****************************************************************
  // Automatic mode follows link state; changes wait for an idle wire.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      port_r <= MLC_PORT_TP;
    else if (!i_tx_busy)
    begin
      case (port_r)
        MLC_PORT_TP:
          if (line_r[`MLC_BIT_AUI_ONLY] ||
              (line_r[`MLC_BIT_AUTO_SEL] && !i_link_ok))
            port_r <= MLC_PORT_AUI; // RL16
        MLC_PORT_AUI:
          if (!line_r[`MLC_BIT_AUI_ONLY] &&
              (!line_r[`MLC_BIT_AUTO_SEL] || i_link_ok))
            port_r <= MLC_PORT_TP; // RL16
        default:
          port_r <= MLC_PORT_TP;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_use_aui <= 1'b0;
      o_use_tp  <= 1'b0;
    end
    else
    begin
      o_use_aui <= (port_r == MLC_PORT_AUI);
      o_use_tp  <= (port_r == MLC_PORT_TP);
    end
  end

  // ****************************************************************
  // Backoff slot draw.
  // ****************************************************************
  // The modified form raises the exponent by one, doubling the range, for attempts one to three.
  always_comb
  begin
    boff_exp = (i_attempt > `MLC_BOFF_MAX_EXP) ? `MLC_BOFF_MAX_EXP
                                                : i_attempt; // RL12
    if (line_r[`MLC_BIT_MOD_BOFF] && i_attempt != 4'h0 &&
        i_attempt <= `MLC_BOFF_MOD_LAST)
      boff_exp = i_attempt + 4'h1; // RL13
  end

  assign boff_mask = 10'((11'h001 << boff_exp) - 11'h001);

  // A free-running LFSR supplies the pseudo-random slot count.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lfsr_r <= `MLC_LFSR_SEED;
    else
      lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_backoff_slots <= 10'h000;
      o_backoff_valid <= 1'b0;
    end
    else
    begin
      o_backoff_valid <= i_backoff_req;
      if (i_backoff_req)
        o_backoff_slots <= lfsr_r & boff_mask; // RL12 RL13
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  sequence s_lost_half;
    i_lost_tally_half_irq_enable && lost_inc && !rd_lost
      && lost_r == 10'h1ff;
  endsequence
  sequence s_col_half;
    i_collision_tally_half_irq_enable && col_inc && !rd_col
      && col_r == 10'h1ff;
  endsequence

  property p_lost_inc;
    lost_inc && !rd_lost |=> lost_r == 10'($past(lost_r) + 10'h001);
  endproperty
  a_lost_inc: assert property (p_lost_inc) else $error("lost tally"); // RL1
  property p_lost_irq;
    s_lost_half |=> o_lost_half_irq && lost_r == 10'h200;
  endproperty
  a_lost_irq: assert property (p_lost_irq) else $error("lost irq"); // RL2
  property p_lost_wrap;
    lost_inc && !rd_lost && lost_r == 10'h3ff |=> lost_r == 10'h000;
  endproperty
  a_lost_wrap: assert property (p_lost_wrap) else $error("lost wrap"); // RL3
  property p_lost_rd;
    rd_lost |=> o_reg_rdata == {$past(lost_r), 6'h10}
      && lost_r <= 10'h001;
  endproperty
  a_lost_rd: assert property (p_lost_rd) else $error("lost read"); // RL4 RL5
  property p_col_inc;
    col_inc && !rd_col |=> col_r == 10'($past(col_r) + 10'h001);
  endproperty
  a_col_inc: assert property (p_col_inc) else $error("col tally"); // RL6
  property p_col_irq;
    s_col_half |=> o_col_half_irq ##1 !o_col_half_irq;
  endproperty
  a_col_irq: assert property (p_col_irq) else $error("col irq"); // RL7
  property p_col_rd;
    rd_col |=> o_reg_rdata == {$past(col_r), 6'h12} && col_r <= 10'h001;
  endproperty
  a_col_rd: assert property (p_col_rd) else $error("col read"); // RL9 RL10
  property p_line_id;
    line_r[5:0] == 6'h13;
  endproperty
  a_line_id: assert property (p_line_id) else $error("line id"); // RL11
  property p_rx_hold;
    i_rx_busy |=> o_rx_gate == $past(o_rx_gate);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx gate"); // RL17
  property p_aui_only;
    line_r[8] && !i_tx_busy |=> ##1 o_use_aui;
  endproperty
  a_aui_only: assert property (p_aui_only) else $error("aui only"); // RL16
  property p_boff_std;
    i_backoff_req && !line_r[11] && i_attempt == 4'h1
      |=> o_backoff_slots == ($past(lfsr_r) & 10'h001);
  endproperty
  a_boff_std: assert property (p_boff_std) else $error("std boff"); // RL12
  property p_boff_mod;
    i_backoff_req && line_r[11] && i_attempt == 4'h1
      |=> o_backoff_slots == ($past(lfsr_r) & 10'h003);
  endproperty
  a_boff_mod: assert property (p_boff_mod) else $error("mod boff"); // RL13
endmodule
`default_nettype wire

// >>> shared/mlc_regs.svh
`ifndef MLC_REGS_SVH
`define MLC_REGS_SVH
// ****************************************************************
// Register offsets, fields and reset values.
// ****************************************************************
`define MLC_OFS_LINE_CFG   16'h0112
`define MLC_OFS_LOST_CNT   16'h0130
`define MLC_OFS_COL_CNT    16'h0132
`define MLC_ID_LOST        6'h10
`define MLC_ID_COL         6'h12
`define MLC_ID_LINE        6'h13
`define MLC_LINE_RST       16'h0013
`define MLC_LINE_WMASK     16'h7fc0
`define MLC_TALLY_LSB      6
`define MLC_TALLY_HALF_M1  10'h1ff
`define MLC_BIT_RX_EN      6
`define MLC_BIT_TX_EN      7
`define MLC_BIT_AUI_ONLY   8
`define MLC_BIT_AUTO_SEL   9
`define MLC_BIT_MOD_BOFF   11
`define MLC_BIT_POL_DIS    12
`define MLC_BIT_DEF_DIS    13
`define MLC_BOFF_MAX_EXP   4'ha
`define MLC_BOFF_MOD_LAST  4'h3
`define MLC_LFSR_SEED      10'h2a5
`endif

// >>> shared/mlc_pkg.sv
// ****************************************************************
// Shared types of the counters and line configuration block.
// ****************************************************************
package mlc_pkg;
  typedef logic [15:0] mlc_word_t;
  typedef logic [9:0]  mlc_tally_t;
  typedef logic [3:0]  mlc_attempt_t;
  // Physical port in use; one-hot.
  typedef enum logic [1:0] {
    MLC_PORT_TP  = 2'b01,
    MLC_PORT_AUI = 2'b10
  } mlc_port_t;
endpackage

// >>> bench/mlc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ******
// Host processor on the register port.
// ******
module mlc_host_model (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_rdata,
  output logic [15:0]      o_addr,
  output logic             o_rd,
  output logic             o_wr,
  output logic [15:0]      o_wdata
);
  // Idle bus at time zero.
  initial
  begin
    o_addr = 16'h0000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 16'h0000;
  end
  // One access per call; the strobe lasts one cycle, then an idle cycle
  // follows so that two calls never meet in one time step.
  // Idle lines are flipped so a stale value never looks valid.
  task automatic acc(input logic w, input logic [15:0] a, d,
                     output logic [15:0] q);
    o_addr = a;
    o_wdata = d;
    o_rd = !w;
    o_wr = w;
    @(posedge i_mclk);
    #1;
    q = i_rdata;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    @(posedge i_mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> bench/mlc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mlc_top_tb;
  logic i_mclk, i_rst_n, i_reg_rd, i_reg_wr, i_rx_frame_lost;
  logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic i_lost_tally_half_irq_enable, o_lost_half_irq;
  logic i_collision_tally_half_irq_enable, o_col_half_irq;
  logic i_rx_busy, i_rx_data, i_rx_pol_reversed, o_rx_data_fixed;
  logic o_rx_gate, i_tx_busy, i_col_sense, i_link_ok;
  logic i_backoff_req, o_tx_gate, o_two_part_defer, o_use_aui;
  logic o_use_tp, o_backoff_valid;
  logic [3:0] i_attempt;
  logic [9:0] o_backoff_slots;
  int error_cnt, total_checks, cyc;
  // ******
  // Design and host.
  // ******
  mlc_top dut_u (.i_mclk, .i_rst_n, .i_reg_addr, .i_reg_rd, .i_reg_wr,
    .i_reg_wdata, .o_reg_rdata, .i_lost_tally_half_irq_enable,
    .i_collision_tally_half_irq_enable, .o_lost_half_irq,
    .o_col_half_irq, .i_rx_frame_lost, .i_rx_busy, .i_rx_data,
    .i_rx_pol_reversed, .o_rx_data_fixed, .o_rx_gate, .i_tx_busy,
    .i_col_sense, .i_link_ok, .i_backoff_req, .i_attempt, .o_tx_gate,
    .o_two_part_defer, .o_use_aui, .o_use_tp, .o_backoff_slots,
    .o_backoff_valid);
  mlc_host_model host_u (.i_mclk, .i_rdata(o_reg_rdata),
    .o_addr(i_reg_addr), .o_rd(i_reg_rd), .o_wr(i_reg_wr),
    .o_wdata(i_reg_wdata));
  // Clock of 4 ns.
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // Cut a hang short well beyond the expected run of some 5300 cycles.
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(input logic [15:0] a, e);
    logic [15:0] q;
    host_u.acc(1'b0, a, 16'h0000, q);
    chk("rdata", q, e);
  endtask
  // Write the line register and let gates and port settle.
  task automatic wl(input logic [15:0] d);
    logic [15:0] q;
    host_u.acc(1'b1, 16'h0112, d, q);
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  // Events spaced two cycles apart; read twice to see the clear.
  task automatic cnt(input logic c, b, input int n, ni,
                     input logic [15:0] a, e);
    int k;
    k = 0;
    i_tx_busy = b;
    repeat (n)
    begin
      i_col_sense = c;
      i_rx_frame_lost = !c;
      @(posedge i_mclk);
      #1;
      i_col_sense = 1'b0;
      i_rx_frame_lost = 1'b0;
      if ((c ? o_col_half_irq : o_lost_half_irq) === 1'b1)
        k++;
      @(posedge i_mclk);
      #1;
    end
    i_tx_busy = 1'b0;
    chk("irq", 16'(k), 16'(ni));
    rd(a, e);
    rd(a, {10'h000, e[5:0]});
  endtask
  task automatic line_t();
    i_link_ok = 1'b1;
    i_rx_pol_reversed = 1'b1;
    i_rx_data = 1'b1;
    wl(16'hffff);
    rd(16'h0112, 16'h7fd3);
    chk("gate", 16'({o_rx_gate, o_tx_gate}), 16'h3);
    chk("port", 16'({o_use_aui, o_use_tp}), 16'h2);
    chk("defer", 16'(o_two_part_defer), 16'h0);
    chk("pol", 16'(o_rx_data_fixed), 16'h1);
    wl(16'h00c0);
    chk("pol", 16'(o_rx_data_fixed), 16'h0);
    chk("defer", 16'(o_two_part_defer), 16'h1);
    chk("port", 16'({o_use_aui, o_use_tp}), 16'h1);
    wl(16'h02c0);
    chk("port", 16'({o_use_aui, o_use_tp}), 16'h1);
    i_link_ok = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("port", 16'({o_use_aui, o_use_tp}), 16'h2);
    i_rx_busy = 1'b1;
    i_tx_busy = 1'b1;
    wl(16'h0000);
    chk("gate", 16'({o_rx_gate, o_tx_gate}), 16'h3);
    i_rx_busy = 1'b0;
    i_tx_busy = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("gate", 16'({o_rx_gate, o_tx_gate}), 16'h0);
  endtask
  // Four draws; no slot count may exceed the range mask.
  task automatic bo(input logic [15:0] l, input logic [3:0] a,
                    input logic [9:0] m);
    wl(l);
    repeat (4)
    begin
      i_attempt = a;
      i_backoff_req = 1'b1;
      @(posedge i_mclk);
      #1;
      i_backoff_req = 1'b0;
      chk("valid", 16'(o_backoff_valid), 16'h1);
      chk("slots", 16'(o_backoff_slots & ~m), 16'h0000);
      @(posedge i_mclk);
      #1;
    end
  endtask
  // Main sequence.
  initial
  begin
    {i_rst_n, i_rx_frame_lost, i_rx_busy, i_rx_data} = 4'h0;
    {i_rx_pol_reversed, i_tx_busy, i_col_sense, i_link_ok} = 4'h0;
    {i_lost_tally_half_irq_enable, i_backoff_req} = 2'h0;
    i_collision_tally_half_irq_enable = 1'b0;
    i_attempt = 4'h1;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    rd(16'h0112, 16'h0013);
    rd(16'h0130, 16'h0010);
    rd(16'h0132, 16'h0012);
    rd(16'h0200, 16'h0000);
    chk("port", 16'({o_use_aui, o_use_tp}), 16'h1);
    chk("defer", 16'(o_two_part_defer), 16'h1);
    chk("gate", 16'({o_rx_gate, o_tx_gate}), 16'h0);
    cnt(1'b0, 1'b0, 3, 0, 16'h0130, 16'h00d0);
    cnt(1'b1, 1'b1, 2, 0, 16'h0132, 16'h0092);
    cnt(1'b1, 1'b0, 3, 0, 16'h0132, 16'h0012);
    i_lost_tally_half_irq_enable = 1'b1;
    cnt(1'b0, 1'b0, 1024, 1, 16'h0130, 16'h0010);
    cnt(1'b1, 1'b1, 512, 0, 16'h0132, 16'h8012);
    i_collision_tally_half_irq_enable = 1'b1;
    cnt(1'b1, 1'b1, 1024, 1, 16'h0132, 16'h0012);
    line_t();
    bo(16'h0000, 4'h1, 10'h001);
    bo(16'h0000, 4'hc, 10'h3ff);
    bo(16'h0800, 4'h1, 10'h003);
    bo(16'h0800, 4'h3, 10'h00f);
    bo(16'h0800, 4'h4, 10'h00f);
    tally_and_finish();
  end
endmodule
`default_nettype wire
